// ===== core/ldcs_map.svh
`ifndef LDCS_MAP_SVH
`define LDCS_MAP_SVH
// Behaviour
// - Bit 6 of 0x2c holds keyboard controller reset
// - Low byte first; high byte write relocates immediately
// - Relocated address cleared by hard or main reset
// - Strap pin picks default address 0x2e or 0x4e
// - Power bit 5 cleared by standby reset only
// - Eight banks selected by logical device number
// - Index port selects, data port accesses register
// - Registers reachable only in configuration state
// - Activate bit 0 enables selected device
// - Reserved bank ranges ignore writes, read zero
// - Activate and power bits are one linked bit
// - Device number selects bank; activate acts there

// ****************************************
// Register indices
// ****************************************
`define LDCS_IDX_LDN      8'h07
`define LDCS_IDX_PWR      8'h22
`define LDCS_IDX_ADDR_LO  8'h26
`define LDCS_IDX_ADDR_HI  8'h27
`define LDCS_IDX_FAC_D    8'h2b
`define LDCS_IDX_FAC_KBC  8'h2c
`define LDCS_IDX_FAC_A    8'h2d
`define LDCS_IDX_FAC_B    8'h2e
`define LDCS_IDX_FAC_C    8'h2f
`define LDCS_IDX_ACT      8'h30
`define LDCS_IDX_RSV_LO   8'h31
`define LDCS_IDX_RSV_HI   8'h5f

// ****************************************
// Fields, defaults
// ****************************************
`define LDCS_KBC_BIT      6
`define LDCS_SP2_BIT      5
`define LDCS_ACT_BIT      0
`define LDCS_DEF_ADDR_0   16'h002e
`define LDCS_DEF_ADDR_1   16'h004e
`define LDCS_ZERO_BYTE    8'h00
`endif

// ===== core/ldcs_pkg.sv
package ldcs_pkg;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } ldcs_io_s;

   typedef enum logic [1:0] {
      PORT_NONE,
      PORT_INDEX,
      PORT_DATA
   } ldcs_port_e;
endpackage

// ===== core/ldcs_top.sv
`include "ldcs_map.svh"

module ldcs_top import ldcs_pkg::*; (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        vcc_por,
   input  wire logic        standby_power_on_reset,
   input  wire logic        hard_rst,
   input  wire logic        soft_rst,
   input  wire logic        cfg_state,
   input  wire logic        addr_strap,
   input  wire ldcs_io_s    io_req,
   output logic      [7:0]  io_rdata,
   output logic             io_rvalid,
   output logic             kbc_hold,
   output logic      [7:0]  dev_active,
   output logic      [15:0] cfg_addr
);

   // ****************************************
   // Strap synchroniser
   // ****************************************
   logic       strap_s1;
   logic       strap_s2;
   logic       strap_s3;
   logic       strap_lvl;
   logic       next_strap_lvl;

   always_comb begin
      next_strap_lvl = strap_lvl;
      if (strap_s2 == strap_s3) begin
         next_strap_lvl = strap_s3;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         strap_s1  <= 1'b0;
         strap_s2  <= 1'b0;
         strap_s3  <= 1'b0;
         strap_lvl <= 1'b0;
      end else begin
         strap_s1  <= addr_strap;
         strap_s2  <= strap_s1;
         strap_s3  <= strap_s2;
         strap_lvl <= next_strap_lvl;
      end
   end

   // ****************************************
   // Port decode
   // ****************************************
   logic [15:0] def_addr;
   logic [15:0] data_addr;
   logic [15:0] base_q;
   logic        reloc_q;
   ldcs_port_e  port_sel;

   assign def_addr  = strap_lvl ? `LDCS_DEF_ADDR_1 : `LDCS_DEF_ADDR_0;
   assign cfg_addr  = reloc_q ? base_q : def_addr;
   assign data_addr = cfg_addr + 16'h0001;

   always_comb begin
      port_sel = PORT_NONE;
      if (cfg_state && io_req.addr == cfg_addr) begin
         port_sel = PORT_INDEX;
      end else if (cfg_state && io_req.addr == data_addr) begin
         port_sel = PORT_DATA;
      end
   end

   // ****************************************
   // Register state
   // ****************************************
   logic [7:0]  index_q;
   logic [7:0]  ldn_q;
   logic [7:0]  lo_q;
   logic [7:0]  dev_on_q;
   logic [7:0]  fac_q [5];
   logic [7:0]  rd_mux;
   logic        data_wr;
   logic        pwr_rst;
   logic        addr_rst;
   logic        any_rst;
   logic [7:0]  next_index_q;
   logic [7:0]  next_ldn_q;
   logic [7:0]  next_lo_q;
   logic [15:0] next_base_q;
   logic        next_reloc_q;
   logic [7:0]  next_dev_on_q;
   logic [7:0]  next_fac_q [5];
   logic [7:0]  next_io_rdata;

   assign data_wr  = io_req.wr && port_sel == PORT_DATA;
   assign pwr_rst  = vcc_por || standby_power_on_reset;
   assign addr_rst = vcc_por || hard_rst;
   assign any_rst  = pwr_rst || hard_rst || soft_rst;

   always_comb begin
      next_index_q  = index_q;
      next_ldn_q    = ldn_q;
      next_lo_q     = lo_q;
      next_base_q   = base_q;
      next_reloc_q  = reloc_q;
      next_dev_on_q = dev_on_q;
      next_fac_q    = fac_q;
      if (io_req.wr && port_sel == PORT_INDEX) begin
         next_index_q = io_req.wdata;
      end
      if (data_wr) begin
         case (index_q)
            `LDCS_IDX_LDN: begin
               next_ldn_q = {5'h00, io_req.wdata[2:0]};
            end
            `LDCS_IDX_PWR: begin
               next_dev_on_q = io_req.wdata;
            end
            `LDCS_IDX_ADDR_LO: begin
               next_lo_q = {io_req.wdata[7:1], 1'b0};
            end
            `LDCS_IDX_ADDR_HI: begin
               next_base_q  = {io_req.wdata, lo_q};
               next_reloc_q = 1'b1;
            end
            `LDCS_IDX_FAC_D, `LDCS_IDX_FAC_KBC, `LDCS_IDX_FAC_A, `LDCS_IDX_FAC_B, `LDCS_IDX_FAC_C: begin
               next_fac_q[3'(index_q - `LDCS_IDX_FAC_D)] = io_req.wdata;
            end
            `LDCS_IDX_ACT: begin
               next_dev_on_q[ldn_q[2:0]] = io_req.wdata[`LDCS_ACT_BIT];
            end
            default: begin
               next_index_q = index_q;
            end
         endcase
      end
      if (any_rst) begin
         next_ldn_q = `LDCS_ZERO_BYTE;
         next_dev_on_q[`LDCS_SP2_BIT-1:0] = 5'h00;
         next_dev_on_q[7:`LDCS_SP2_BIT+1] = 2'h0;
      end
      if (standby_power_on_reset) begin
         next_dev_on_q[`LDCS_SP2_BIT] = 1'b0;
      end
      if (addr_rst) begin
         next_reloc_q = 1'b0;
         next_lo_q    = `LDCS_ZERO_BYTE;
         next_base_q  = 16'h0000;
      end
      if (pwr_rst) begin
         for (int i = 0; i < 5; i++) begin
            next_fac_q[i] = `LDCS_ZERO_BYTE;
         end
      end
   end

   always_comb begin
      rd_mux = `LDCS_ZERO_BYTE;
      if (port_sel == PORT_INDEX) begin
         rd_mux = index_q;
      end else if (port_sel == PORT_DATA) begin
         case (index_q)
            `LDCS_IDX_LDN:     rd_mux = ldn_q;
            `LDCS_IDX_PWR:     rd_mux = dev_on_q;
            `LDCS_IDX_ADDR_LO: rd_mux = cfg_addr[7:0];
            `LDCS_IDX_ADDR_HI: rd_mux = cfg_addr[15:8];
            `LDCS_IDX_FAC_D, `LDCS_IDX_FAC_KBC, `LDCS_IDX_FAC_A, `LDCS_IDX_FAC_B, `LDCS_IDX_FAC_C: begin
               rd_mux = fac_q[3'(index_q - `LDCS_IDX_FAC_D)];
            end
            `LDCS_IDX_ACT:     rd_mux = {7'h00, dev_on_q[ldn_q[2:0]]};
            default:           rd_mux = `LDCS_ZERO_BYTE;
         endcase
      end
      next_io_rdata = io_req.rd ? rd_mux : io_rdata;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         index_q   <= `LDCS_ZERO_BYTE;
         ldn_q     <= `LDCS_ZERO_BYTE;
         lo_q      <= `LDCS_ZERO_BYTE;
         base_q    <= 16'h0000;
         reloc_q   <= 1'b0;
         dev_on_q  <= `LDCS_ZERO_BYTE;
         fac_q     <= '{default: `LDCS_ZERO_BYTE};
         io_rdata  <= `LDCS_ZERO_BYTE;
         io_rvalid <= 1'b0;
      end else begin
         index_q   <= next_index_q;
         ldn_q     <= next_ldn_q;
         lo_q      <= next_lo_q;
         base_q    <= next_base_q;
         reloc_q   <= next_reloc_q;
         dev_on_q  <= next_dev_on_q;
         fac_q     <= next_fac_q;
         io_rdata  <= next_io_rdata;
         io_rvalid <= io_req.rd && port_sel != PORT_NONE;
      end
   end

   assign kbc_hold   = fac_q[1][`LDCS_KBC_BIT];
   assign dev_active = dev_on_q;

   // ****************************************
   // Checks
   // ****************************************
   property p_kbc;
      @(posedge clk) disable iff (!rst_b)
      (data_wr && index_q == `LDCS_IDX_FAC_KBC && !pwr_rst) |=> kbc_hold == $past(io_req.wdata[6]);
   endproperty
   a_kbc: assert property (p_kbc) else $error("kbc hold not following write");

   property p_reloc;
      @(posedge clk) disable iff (!rst_b)
      (data_wr && index_q == `LDCS_IDX_ADDR_HI && !addr_rst) |=> cfg_addr == {$past(io_req.wdata), lo_q};
   endproperty
   a_reloc: assert property (p_reloc) else $error("config address not moved");

   property p_keep_addr;
      @(posedge clk) disable iff (!rst_b)
      (!addr_rst && !(data_wr && index_q == `LDCS_IDX_ADDR_HI) && reloc_q) |=> $stable(cfg_addr);
   endproperty
   a_keep_addr: assert property (p_keep_addr) else $error("config address changed");

   property p_default;
      @(posedge clk) disable iff (!rst_b)
      addr_rst |=> cfg_addr == (strap_lvl ? 16'h004e : 16'h002e);
   endproperty
   a_default: assert property (p_default) else $error("default address wrong");

   property p_sp2;
      @(posedge clk) disable iff (!rst_b)
      (!standby_power_on_reset && !data_wr) |=> $stable(dev_on_q[5]);
   endproperty
   a_sp2: assert property (p_sp2) else $error("serial 2 power bit disturbed");

   property p_cfg_only;
      @(posedge clk) disable iff (!rst_b)
      (!cfg_state && !any_rst) |=> $stable(ldn_q) && $stable(dev_on_q) && $stable(index_q);
   endproperty
   a_cfg_only: assert property (p_cfg_only) else $error("access outside configuration state");

   property p_act;
      @(posedge clk) disable iff (!rst_b)
      (data_wr && index_q == `LDCS_IDX_ACT && !any_rst) |=> dev_active[ldn_q[2:0]] == $past(io_req.wdata[0]);
   endproperty
   a_act: assert property (p_act) else $error("activate did not reach device");

   property p_rsv;
      @(posedge clk) disable iff (!rst_b)
      (io_req.rd && port_sel == PORT_DATA && index_q >= 8'h31 && index_q <= 8'h5f) |=> io_rdata == 8'h00;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved read not zero");

   property p_fac_rst;
      @(posedge clk) disable iff (!rst_b)
      pwr_rst |=> kbc_hold == 1'b0 && fac_q[0] == 8'h00;
   endproperty
   a_fac_rst: assert property (p_fac_rst) else $error("factory register not cleared");

   property p_index;
      @(posedge clk) disable iff (!rst_b)
      (io_req.wr && port_sel == PORT_INDEX) |=> index_q == $past(io_req.wdata);
   endproperty
   a_index: assert property (p_index) else $error("index not taken");

endmodule

// ===== dv/ldcs_host.sv
`include "ldcs_map.svh"

module ldcs_host import ldcs_pkg::*; (
   input  wire logic       clk,
   output ldcs_io_s        io_req,
   input  wire logic [7:0] io_rdata,
   input  wire logic       io_rvalid
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] port;
   logic [7:0]  lo;
   logic        seen;
   initial begin
      io_req = '0;
      port = 16'h002e;
      lo = 8'h2e;
      seen = 1'b0;
   end
   // ****************************************
   // One bus cycle, then strobes cleared, address and data inverted
   // ****************************************
   task automatic cyc(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge clk);
      io_req <= '{wr: w, rd: r, addr: a, wdata: d};
      @(posedge clk);
      io_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      #1;
      seen = io_rvalid;
      q = io_rdata;
   endtask
   task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      logic [7:0] v;
      v = d;
      if (idx == `LDCS_IDX_ACT) v[7:1] = 7'h00;
      if (idx == `LDCS_IDX_ADDR_LO) v[0] = 1'b0;
      cyc(1'b1, 1'b0, port, idx, q);
      cyc(1'b1, 1'b0, port + 16'h0001, v, q);
      if (idx == `LDCS_IDX_ADDR_LO) lo = v;
      if (idx == `LDCS_IDX_ADDR_HI) port = {v, lo};
   endtask
   task automatic rd_reg(input logic [7:0] idx, output logic [7:0] q);
      cyc(1'b1, 1'b0, port, idx, q);
      cyc(1'b0, 1'b1, port + 16'h0001, 8'h00, q);
   endtask
   // Keyboard hold changed by read-modify-write only
   task automatic set_kbc(input logic b);
      logic [7:0] q;
      rd_reg(`LDCS_IDX_FAC_KBC, q);
      q[`LDCS_KBC_BIT] = b;
      wr_reg(`LDCS_IDX_FAC_KBC, q);
   endtask
endmodule

// ===== dv/ldcs_top_tb.sv
`include "ldcs_map.svh"

module ldcs_top_tb import ldcs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        vcc_por = 1'b0;
   logic        standby_power_on_reset = 1'b0;
   logic        hard_rst = 1'b0;
   logic        soft_rst = 1'b0;
   logic        cfg_state = 1'b1;
   logic        addr_strap = 1'b0;
   ldcs_io_s    io_req;
   logic [7:0]  io_rdata;
   logic        io_rvalid;
   logic        kbc_hold;
   logic [7:0]  dev_active;
   logic [15:0] cfg_addr;
   logic [7:0]  exp_on;
   int          fail_count = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   initial forever #25 clk = ~clk;
   ldcs_top u_ldcs_top (.clk(clk), .rst_b(rst_b), .vcc_por(vcc_por),
      .standby_power_on_reset(standby_power_on_reset), .hard_rst(hard_rst), .soft_rst(soft_rst),
      .cfg_state(cfg_state), .addr_strap(addr_strap), .io_req(io_req), .io_rdata(io_rdata),
      .io_rvalid(io_rvalid), .kbc_hold(kbc_hold), .dev_active(dev_active), .cfg_addr(cfg_addr));
   ldcs_host u_ldcs_host (.clk(clk), .io_req(io_req), .io_rdata(io_rdata), .io_rvalid(io_rvalid));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      u_ldcs_host.wr_reg(i, d);
   endtask
   task automatic rdc(input logic [7:0] i, input logic [7:0] e);
      logic [7:0] q;
      u_ldcs_host.rd_reg(i, q);
      chk(16'(q), 16'(e));
   endtask
   // Pulse side resets {vcc, standby, hard, soft}
   task automatic side(input logic [3:0] s);
      @(posedge clk);
      {vcc_por, standby_power_on_reset, hard_rst, soft_rst} <= s;
      @(posedge clk);
      {vcc_por, standby_power_on_reset, hard_rst, soft_rst} <= 4'h0;
      @(posedge clk);
      #1;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      chk(cfg_addr, `LDCS_DEF_ADDR_0);
      chk(16'(dev_active), 16'h0000);
      for (int i = 8'h2b; i <= 8'h2f; i++) rdc(8'(i), 8'h00);
   endtask
   task automatic t_kbc;
      u_ldcs_host.set_kbc(1'b1);
      chk(16'(kbc_hold), 16'h0001);
      rdc(`LDCS_IDX_FAC_KBC, 8'h40);
      u_ldcs_host.set_kbc(1'b0);
      chk(16'(kbc_hold), 16'h0000);
   endtask
   task automatic t_banks;
      exp_on = 8'h00;
      for (int n = 0; n < 8; n++) begin
         wr(`LDCS_IDX_LDN, 8'(n));
         wr(`LDCS_IDX_ACT, 8'hff);
         exp_on[n] = 1'b1;
         chk(16'(dev_active), 16'(exp_on));
         rdc(`LDCS_IDX_ACT, 8'h01);
      end
      wr(`LDCS_IDX_LDN, 8'h03);
      wr(`LDCS_IDX_ACT, 8'h00);
      exp_on[3] = 1'b0;
      chk(16'(dev_active), 16'(exp_on));
      rdc(`LDCS_IDX_PWR, exp_on);
      exp_on[4] = 1'b0;
      wr(`LDCS_IDX_PWR, exp_on);
      wr(`LDCS_IDX_LDN, 8'h04);
      rdc(`LDCS_IDX_ACT, 8'h00);
   endtask
   task automatic t_rsv;
      logic [7:0] ix [6] = '{8'h31, 8'h37, 8'h38, 8'h3f, 8'h40, 8'h5f};
      foreach (ix[k]) begin
         wr(ix[k], 8'hff);
         rdc(ix[k], 8'h00);
      end
   endtask
   task automatic t_cfg;
      logic [7:0] q;
      @(posedge clk);
      cfg_state <= 1'b0;
      wr(`LDCS_IDX_PWR, 8'h00);
      chk(16'(dev_active), 16'(exp_on));
      u_ldcs_host.rd_reg(`LDCS_IDX_PWR, q);
      chk(16'(u_ldcs_host.seen), 16'h0000);
      @(posedge clk);
      cfg_state <= 1'b1;
      u_ldcs_host.rd_reg(`LDCS_IDX_PWR, q);
      chk(16'(u_ldcs_host.seen), 16'h0001);
      chk(16'(q), 16'(exp_on));
      u_ldcs_host.cyc(1'b0, 1'b1, u_ldcs_host.port, 8'h00, q);
      chk(16'(q), 16'(`LDCS_IDX_PWR));
   endtask
   task automatic t_reloc;
      logic [7:0] q;
      wr(`LDCS_IDX_ADDR_LO, 8'h61);
      wr(`LDCS_IDX_ADDR_HI, 8'h12);
      chk(cfg_addr, 16'h1260);
      rdc(`LDCS_IDX_ADDR_LO, 8'h60);
      rdc(`LDCS_IDX_ADDR_HI, 8'h12);
      u_ldcs_host.cyc(1'b0, 1'b1, `LDCS_DEF_ADDR_0 + 16'h0001, 8'h00, q);
      chk(16'(u_ldcs_host.seen), 16'h0000);
   endtask
   task automatic t_resets;
      u_ldcs_host.set_kbc(1'b1);
      @(posedge clk);
      addr_strap <= 1'b1;
      side(4'b0001);
      chk(16'(dev_active), 16'(exp_on & 8'h20));
      chk(cfg_addr, 16'h1260);
      chk(16'(kbc_hold), 16'h0001);
      side(4'b0100);
      chk(16'(dev_active), 16'h0000);
      chk(cfg_addr, 16'h1260);
      chk(16'(kbc_hold), 16'h0000);
      wr(`LDCS_IDX_LDN, 8'h05);
      wr(`LDCS_IDX_ACT, 8'h01);
      u_ldcs_host.set_kbc(1'b1);
      side(4'b0010);
      chk(cfg_addr, `LDCS_DEF_ADDR_1);
      chk(16'(dev_active), 16'h0020);
      chk(16'(kbc_hold), 16'h0001);
      u_ldcs_host.port = `LDCS_DEF_ADDR_1;
      rdc(`LDCS_IDX_ADDR_LO, 8'h4e);
      @(posedge clk);
      addr_strap <= 1'b0;
      repeat (6) @(posedge clk);
      side(4'b1000);
      chk(cfg_addr, `LDCS_DEF_ADDR_0);
      chk(16'(dev_active), 16'h0020);
      chk(16'(kbc_hold), 16'h0000);
      u_ldcs_host.port = `LDCS_DEF_ADDR_0;
      rdc(`LDCS_IDX_ADDR_HI, 8'h00);
   endtask
   // ****************************************
   // Sequence and timeout
   // ****************************************
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         end_of_test();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      t_reset();
      t_kbc();
      t_banks();
      t_rsv();
      t_cfg();
      t_reloc();
      t_resets();
      end_of_test();
   end
endmodule
